// file: src/cpp_pkg.sv
package cpp_pkg;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   localparam int CNT_W = 16;
   localparam int PRESC_W = 11;
   localparam int LF_PRESC_W = 3;
   // Register byte addresses
   localparam logic [ADDR_W-1:0] OFF_LCTL = 5'h00;
   localparam logic [ADDR_W-1:0] OFF_UCTL = 5'h04;
   localparam logic [ADDR_W-1:0] OFF_PWL = 5'h08;
   localparam logic [ADDR_W-1:0] OFF_PWH = 5'h0c;
   localparam logic [ADDR_W-1:0] OFF_PERL = 5'h10;
   localparam logic [ADDR_W-1:0] OFF_PERH = 5'h14;
   localparam logic [ADDR_W-1:0] OFF_CNT = 5'h18;
   // Control fields
   localparam int UCTL_FF_BIT = 7;
   localparam int UCTL_RUN_BIT = 3;
   localparam int MODE_MSB = 2;
   localparam int CLK_MSB = 6;
   localparam int CLK_LSB = 4;
   localparam logic [2:0] UMODE_PWM16 = 3'h6;
   localparam logic [2:0] UMODE_PPG16 = 3'h7;
   localparam logic [2:0] LMODE_CASCADE = 3'h3;
   // Source clock taps
   localparam logic [2:0] CLK_DIV11 = 3'h0;
   localparam logic [2:0] CLK_DIV7 = 3'h1;
   localparam logic [2:0] CLK_DIV5 = 3'h2;
   localparam logic [2:0] CLK_DIV3 = 3'h3;
   localparam logic [2:0] CLK_LF = 3'h4;
   localparam logic [2:0] CLK_DIV1 = 3'h5;
   localparam logic [2:0] CLK_FULL = 3'h6;
   // Reset and limit values
   localparam logic [7:0] CTL_RST = 8'h00;
   localparam logic [CNT_W-1:0] WORD_RST = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
endpackage

// file: src/cpp_timer.sv
module cpp_timer
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [cpp_pkg::ADDR_W-1:0] paddr,
   input wire logic [cpp_pkg::DATA_W-1:0] pwdata,
   output logic [cpp_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic low_freq_clock,
   input wire logic divider_tap_select,
   input wire logic slow_mode,
   output logic pwm_out_pin,
   output logic pulse_gen_out_pin,
   output logic upper_timer_irq
);
   import cpp_pkg::*;

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic ff;
      logic [CNT_W-1:0] pw_buf;
      logic [CNT_W-1:0] pw_act;
      logic [CNT_W-1:0] per;
      logic [7:0] lctl;
      logic [7:0] uctl;
      logic [PRESC_W-1:0] presc;
      logic [LF_PRESC_W-1:0] lf_presc;
      logic [2:0] lf_s;
      logic [1:0] dts_s;
      logic [1:0] slow_s;
      logic irq;
      logic pin;
      logic [DATA_W-1:0] prdata;
      logic pready;
      logic pslverr;
   } cpp_state_type;

   cpp_state_type st_r;
   cpp_state_type st_nxt;
   logic lf_edge;
   logic tick;
   logic run;
   logic pwm_mode;
   logic ppg_mode;
   logic wr;
   logic rd_setup;
   logic pw_hit;
   logic end_hit;
   logic [CNT_W-1:0] per_m1;

   // Source clock tap for the selected prescaler output
   function automatic logic src_tick
   (
      input logic [2:0] sel,
      input logic [PRESC_W-1:0] pre,
      input logic lf_e,
      input logic [LF_PRESC_W-1:0] lf_pre,
      input logic dts,
      input logic slow
   );
      logic lf8;
      lf8 = lf_e && (&lf_pre);
      if (slow)
      begin
         // Only slow clock taps run while the fast oscillator is off
         src_tick = ((sel == CLK_DIV11) && lf8) || ((sel == CLK_LF) && lf_e);
      end
      else
      begin
         case (sel)
            CLK_DIV11: src_tick = dts ? lf8 : (&pre[10:0]);
            CLK_DIV7: src_tick = &pre[6:0];
            CLK_DIV5: src_tick = &pre[4:0];
            CLK_DIV3: src_tick = &pre[2:0];
            CLK_LF: src_tick = lf_e;
            CLK_DIV1: src_tick = pre[0];
            CLK_FULL: src_tick = 1'b1;
            default: src_tick = 1'b0;
         endcase
      end
   endfunction

   // Decode of mode and counting conditions
   always_comb
   begin
      lf_edge = st_r.lf_s[1] && !st_r.lf_s[2];
      pwm_mode = (st_r.uctl[MODE_MSB:0] == UMODE_PWM16);
      ppg_mode = (st_r.uctl[MODE_MSB:0] == UMODE_PPG16);
      run = st_r.uctl[UCTL_RUN_BIT] && (st_r.lctl[MODE_MSB:0] == LMODE_CASCADE)
         && (pwm_mode || ppg_mode);
      tick = run && src_tick(st_r.lctl[CLK_MSB:CLK_LSB], st_r.presc, lf_edge,
         st_r.lf_presc, st_r.dts_s[1], st_r.slow_s[1]);
      per_m1 = st_r.per - CNT_ONE;
      pw_hit = (st_r.cnt == st_r.pw_act);
      end_hit = pwm_mode ? (st_r.cnt == CNT_MAX) : (st_r.cnt == per_m1);
      wr = psel && penable && st_r.pready && pwrite;
      rd_setup = psel && !penable && !pwrite;
   end

   // Next state: prescalers, counter, flop, registers and bus answer
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.irq = 1'b0;
      st_nxt.presc = st_r.presc + {{(PRESC_W-1){1'b0}}, 1'b1};
      st_nxt.lf_s = {st_r.lf_s[1:0], low_freq_clock};
      st_nxt.dts_s = {st_r.dts_s[0], divider_tap_select};
      st_nxt.slow_s = {st_r.slow_s[0], slow_mode};
      if (lf_edge)
      begin
         st_nxt.lf_presc = st_r.lf_presc + {{(LF_PRESC_W-1){1'b0}}, 1'b1};
      end
      // Counting; stopped counter leaves the flop untouched
      if (tick)
      begin
         st_nxt.ff = st_r.ff ^ pw_hit ^ end_hit;
         if (end_hit)
         begin
            // Full wrap in PWM, period match in pulse mode
            st_nxt.cnt = WORD_RST;
            st_nxt.irq = 1'b1;
            if (pwm_mode)
            begin
               st_nxt.pw_act = st_r.pw_buf;
            end
         end
         else
         begin
            st_nxt.cnt = st_r.cnt + CNT_ONE;
         end
      end
      // Register writes at the completing access edge
      if (wr)
      begin
         case (paddr)
            OFF_LCTL: st_nxt.lctl = pwdata[7:0];
            OFF_UCTL:
            begin
               st_nxt.uctl = pwdata[7:0];
               // Preload only while stopped, so a stopping write holds the pin
               if (!st_r.uctl[UCTL_RUN_BIT])
               begin
                  st_nxt.ff = pwdata[UCTL_FF_BIT];
               end
               if (!pwdata[UCTL_RUN_BIT] && !st_r.uctl[UCTL_RUN_BIT])
               begin
                  st_nxt.cnt = WORD_RST;
               end
            end
            OFF_PWL:
            begin
               st_nxt.pw_buf[7:0] = pwdata[7:0];
               if (!(pwm_mode && run))
               begin
                  st_nxt.pw_act[7:0] = pwdata[7:0];
               end
            end
            OFF_PWH:
            begin
               st_nxt.pw_buf[15:8] = pwdata[7:0];
               if (!(pwm_mode && run))
               begin
                  st_nxt.pw_act[15:8] = pwdata[7:0];
               end
            end
            OFF_PERL: st_nxt.per[7:0] = pwdata[7:0];
            OFF_PERH: st_nxt.per[15:8] = pwdata[7:0];
            default: st_nxt.per = st_r.per;
         endcase
      end
      // Read data prepared in the setup cycle
      st_nxt.prdata = '0;
      if (rd_setup)
      begin
         case (paddr)
            OFF_LCTL: st_nxt.prdata[7:0] = st_r.lctl;
            OFF_UCTL: st_nxt.prdata[7:0] = st_r.uctl;
            OFF_PWL: st_nxt.prdata[7:0] = st_r.pw_act[7:0];
            OFF_PWH: st_nxt.prdata[7:0] = st_r.pw_act[15:8];
            OFF_PERL: st_nxt.prdata[7:0] = st_r.per[7:0];
            OFF_PERH: st_nxt.prdata[7:0] = st_r.per[15:8];
            OFF_CNT: st_nxt.prdata[CNT_W-1:0] = st_r.cnt;
            default: st_nxt.prdata = '0;
         endcase
      end
      // One-cycle access phase; unmapped addresses answer with an error
      st_nxt.pready = psel && !penable;
      st_nxt.pslverr = psel && !penable && (paddr > OFF_CNT || paddr[1:0] != 2'h0);
      st_nxt.pin = !st_nxt.ff;
   end

   // State register
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_r <= '0;
         st_r.pin <= 1'b1;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // Outputs come straight from the state register
   always_comb
   begin
      prdata = st_r.prdata;
      pready = st_r.pready;
      pslverr = st_r.pslverr;
      pwm_out_pin = st_r.pin;
      pulse_gen_out_pin = st_r.pin;
      upper_timer_irq = st_r.irq;
   end

   default clocking cpp_cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   // Output pins mirror the inverted flop
   pin_invert_a: assert property (pwm_out_pin == !st_r.ff)
      else $error("Output pin is not the inverse of the flop");

   // Stopped counter keeps the pin unless software preloads it
   stop_hold_a: assert property (!run && !wr |=> $stable(pwm_out_pin))
      else $error("Output pin moved while the counter was stopped");

   // PWM wrap clears the counter and raises the irq
   pwm_wrap_a: assert property (tick && pwm_mode && st_r.cnt == CNT_MAX && !wr
      |=> upper_timer_irq && st_r.cnt == WORD_RST)
      else $error("PWM overflow did not clear and interrupt");

   // Pulse mode period match clears the counter and raises the irq
   ppg_period_a: assert property (tick && ppg_mode && st_r.cnt == per_m1 && !wr
      |=> upper_timer_irq && st_r.cnt == WORD_RST)
      else $error("Period match did not clear and interrupt");

   // Counter advances by one on each tick before its end
   count_up_a: assert property (tick && !end_hit && !wr
      |=> st_r.cnt == $past(st_r.cnt) + CNT_ONE)
      else $error("Counter did not advance by one");

   // Holding stage moves to the active value at the wrap
   buffer_load_a: assert property (tick && pwm_mode && end_hit && !wr
      |=> st_r.pw_act == $past(st_r.pw_buf))
      else $error("Held width not transferred at interrupt");

   // Stopped PWM width write lands in the active value
   stopped_write_a: assert property (wr && !run && paddr == OFF_PWL
      |=> st_r.pw_act[7:0] == $past(pwdata[7:0]))
      else $error("Stopped width write not active at once");

   // Width match alone flips the flop
   width_match_a: assert property (tick && pw_hit && !end_hit && !wr
      |=> st_r.ff != $past(st_r.ff))
      else $error("Width match did not invert the flop");

   // Clearing the preload bit while stopped drives the pin high
   flop_clear_a: assert property (wr && paddr == OFF_UCTL
      && !st_r.uctl[UCTL_RUN_BIT] && !pwdata[UCTL_FF_BIT]
      |=> !st_r.ff ##0 pwm_out_pin)
      else $error("Stopped preload write did not clear the flop");

   // Interrupt request lasts one cycle, except for a one-count pulse period
   irq_pulse_a: assert property (upper_timer_irq && !(ppg_mode && st_r.per == CNT_ONE)
      |=> !upper_timer_irq)
      else $error("Interrupt request longer than one cycle");

   // Both output pins show the same level
   pins_agree_a: assert property (pwm_out_pin == pulse_gen_out_pin)
      else $error("Output pins disagree");

   // Pulse mode width match flips the flop and counting goes on
   ppg_width_a: assert property (tick && ppg_mode && pw_hit && !end_hit && !wr
      |=> st_r.ff != $past(st_r.ff) && st_r.cnt == $past(st_r.cnt) + CNT_ONE)
      else $error("Pulse mode width match did not invert the flop");

   // End of a cycle flips the flop when no width match coincides
   end_flip_a: assert property (tick && end_hit && !pw_hit && !wr
      |=> st_r.ff != $past(st_r.ff))
      else $error("Cycle end did not invert the flop");

   // Running PWM width write stays in the holding stage
   held_write_a: assert property (wr && pwm_mode && run && paddr == OFF_PWH && !end_hit
      |=> st_r.pw_act == $past(st_r.pw_act) && st_r.pw_buf[15:8] == $past(pwdata[7:0]))
      else $error("Running width write reached the active value");

   // Width read returns the active value taken at the setup edge
   read_active_a: assert property (psel && !penable && !pwrite && paddr == OFF_PWH
      |=> prdata[7:0] == $past(st_r.pw_act[15:8]))
      else $error("Width read did not return the active value");

   // Stopped counter keeps its value unless a control write clears it
   stopped_count_a: assert property (!run && !wr |=> $stable(st_r.cnt))
      else $error("Counter moved while stopped");

   // The write that stops the counter leaves the pin alone
   stop_write_a: assert property (wr && paddr == OFF_UCTL && !pw_hit && !end_hit
      && st_r.uctl[UCTL_RUN_BIT] |=> $stable(pwm_out_pin))
      else $error("Stopping write changed the output pin");

   // Preload bit set while stopped drives the flop high
   flop_preset_a: assert property (wr && paddr == OFF_UCTL
      && !st_r.uctl[UCTL_RUN_BIT] && pwdata[UCTL_FF_BIT] |=> st_r.ff && !pwm_out_pin)
      else $error("Stopped preload write did not set the flop");

   // Pulse mode period write is active at once
   period_direct_a: assert property (wr && ppg_mode && paddr == OFF_PERL
      |=> st_r.per[7:0] == $past(pwdata[7:0]))
      else $error("Pulse mode period write not active at once");

   // Every irq pulse leaves the counter cleared
   irq_clear_a: assert property (upper_timer_irq |-> st_r.cnt == WORD_RST)
      else $error("Interrupt without a cleared counter");

   // Slow mode lets only the slow taps tick
   slow_refuse_a: assert property (st_r.slow_s[1]
      && st_r.lctl[CLK_MSB:CLK_LSB] != CLK_DIV11 && st_r.lctl[CLK_MSB:CLK_LSB] != CLK_LF
      |-> !tick)
      else $error("Fast tap ticked in slow mode");

   // Slow clock tap ticks on each synchronised rising slow edge
   slow_tap_a: assert property (run && st_r.lctl[CLK_MSB:CLK_LSB] == CLK_LF
      |-> tick == lf_edge)
      else $error("Slow clock tap out of step with the slow edge");

   // PWM raises the irq only at the full wrap
   pwm_period_a: assert property (tick && pwm_mode && st_r.cnt != CNT_MAX
      |=> !upper_timer_irq)
      else $error("PWM interrupt before the full count");

   // PWM width match does not clear the counter
   pwm_width_a: assert property (tick && pwm_mode && pw_hit && !end_hit && !wr
      |=> st_r.cnt == $past(st_r.cnt) + CNT_ONE)
      else $error("PWM width match disturbed the counter");
endmodule

// file: tb/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import cpp_pkg::*;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0;
   logic [DATA_W-1:0] prdata;
   logic pready;
   logic pslverr;
   logic low_freq_clock = 1'b0;
   logic divider_tap_select = 1'b0;
   logic slow_mode = 1'b0;
   logic pwm_out_pin;
   logic pulse_gen_out_pin;
   logic upper_timer_irq;
   logic [DATA_W-1:0] rd;
   logic err;
   int failures = 0;
   int cmp_count = 0;
   int n;
   int lf_div = 0;

   cpp_timer dut_u (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .low_freq_clock(low_freq_clock),
      .divider_tap_select(divider_tap_select), .slow_mode(slow_mode),
      .pwm_out_pin(pwm_out_pin),
      .pulse_gen_out_pin(pulse_gen_out_pin), .upper_timer_irq(upper_timer_irq));

   // System clock
   always #20 clock = ~clock;

   // Slow oscillator stand-in, toggles every five cycles
   always @(posedge clock)
   begin
      lf_div <= (lf_div == 4) ? 0 : lf_div + 1;
      if (lf_div == 4)
         low_freq_clock <= ~low_freq_clock;
   end

   task automatic test_done;
      $display("Checks %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do
      begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic w(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic r(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, e, rd);
   endtask

   task automatic cyc(input int c);
      repeat (c) @(posedge clock);
      #1;
   endtask

   task automatic wait_lvl(input logic v);
      int k;
      k = 0;
      while (pwm_out_pin !== v && k < 70000)
      begin
         cyc(1);
         k++;
      end
   endtask

   // Length of the next low phase of the output pin
   task automatic low_len(output int c);
      c = 0;
      wait_lvl(1'b0);
      while (pwm_out_pin === 1'b0 && c < 70000)
      begin
         cyc(1);
         c++;
      end
   endtask

   // Cycles between two interrupt pulses
   task automatic irq_gap(output int c);
      c = 0;
      while (upper_timer_irq !== 1'b1 && c < 70000)
      begin
         cyc(1);
         c++;
      end
      c = 0;
      do
      begin
         cyc(1);
         c++;
      end while (upper_timer_irq !== 1'b1 && c < 70000);
   endtask

   // Watchdog
   initial
   begin
      #3200000;
      failures++;
      test_done;
   end

   // Main sequence
   initial
   begin
      repeat (6) @(posedge clock);
      rst_b <= 1'b1;
      cyc(3);
      chk("pin after reset", 1, pwm_out_pin);
      chk("pulse pin after reset", 1, pulse_gen_out_pin);
      r("uctl reset", OFF_UCTL, 32'h0000_0000);
      r("unmapped", 5'h1c, 32'h0000_0000);
      chk("slverr", 1, err);
      // Stopped width writes land at once; fc/8 source
      w(OFF_PWL, 32'h0000_00d0);
      w(OFF_PWH, 32'h0000_0007);
      r("width lo", OFF_PWL, 32'h0000_00d0);
      r("width hi", OFF_PWH, 32'h0000_0007);
      w(OFF_LCTL, 32'h0000_0033);
      w(OFF_UCTL, 32'h0000_0056);
      cyc(40);
      r("idle count", OFF_CNT, 32'h0000_0000);
      w(OFF_UCTL, 32'h0000_005e);
      cyc(80);
      apb(1'b0, OFF_CNT, 32'h0000_0000);
      chk("fc/8 count", 1, rd >= 9 && rd <= 12);
      w(OFF_UCTL, 32'h0000_0056);
      // PWM at full rate, width 0100h, then 0200h held
      w(OFF_LCTL, 32'h0000_0063);
      w(OFF_PWL, 32'h0000_0000);
      w(OFF_PWH, 32'h0000_0001);
      w(OFF_UCTL, 32'h0000_0006);
      w(OFF_UCTL, 32'h0000_000e);
      w(OFF_PWL, 32'h0000_0000);
      w(OFF_PWH, 32'h0000_0002);
      r("held hidden", OFF_PWH, 32'h0000_0001);
      low_len(n);
      chk("pwm low", 65279, n);
      chk("irq at wrap", 1, upper_timer_irq);
      r("held moved", OFF_PWH, 32'h0000_0002);
      // Stop while low, then force level through the flop bit
      wait_lvl(1'b0);
      w(OFF_UCTL, 32'h0000_0006);
      cyc(100);
      chk("held pin", 0, pwm_out_pin);
      w(OFF_UCTL, 32'h0000_0006);
      cyc(2);
      chk("cleared flop", 1, pwm_out_pin);
      w(OFF_UCTL, 32'h0000_0086);
      cyc(2);
      chk("preset flop", 0, pwm_out_pin);
      chk("pulse pin preset", 0, pulse_gen_out_pin);
      w(OFF_UCTL, 32'h0000_0006);
      r("count cleared", OFF_CNT, 32'h0000_0000);
      // Pulse mode, period 0020h, width 0008h
      w(OFF_PERL, 32'h0000_0020);
      w(OFF_PERH, 32'h0000_0000);
      w(OFF_PWL, 32'h0000_0008);
      w(OFF_PWH, 32'h0000_0000);
      w(OFF_UCTL, 32'h0000_0007);
      w(OFF_UCTL, 32'h0000_000f);
      low_len(n);
      chk("pulse low", 23, n);
      irq_gap(n);
      chk("pulse period", 32, n);
      w(OFF_UCTL, 32'h0000_0007);
      w(OFF_PERL, 32'h0000_0040);
      r("width direct", OFF_PWL, 32'h0000_0008);
      w(OFF_UCTL, 32'h0000_000f);
      irq_gap(n);
      chk("new period", 64, n);
      // Slow clock tap, fast tap held off in slow mode, then slow/8 tap
      w(OFF_UCTL, 32'h0000_0007);
      w(OFF_LCTL, 32'h0000_0043);
      w(OFF_UCTL, 32'h0000_0007);
      w(OFF_UCTL, 32'h0000_000f);
      cyc(200);
      apb(1'b0, OFF_CNT, 32'h0000_0000);
      chk("slow tap count", 1, rd >= 19 && rd <= 22);
      slow_mode <= 1'b1;
      w(OFF_LCTL, 32'h0000_0013);
      apb(1'b0, OFF_CNT, 32'h0000_0000);
      n = rd;
      cyc(100);
      r("slow mode stop", OFF_CNT, n);
      slow_mode <= 1'b0;
      divider_tap_select <= 1'b1;
      w(OFF_LCTL, 32'h0000_0003);
      apb(1'b0, OFF_CNT, 32'h0000_0000);
      n = rd;
      cyc(400);
      apb(1'b0, OFF_CNT, 32'h0000_0000);
      chk("slow/8 count", 1, rd >= n + 4 && rd <= n + 6);
      w(OFF_UCTL, 32'h0000_0007);
      chk("pins agree", pwm_out_pin, pulse_gen_out_pin);
      test_done;
   end
endmodule
